// file: bench/divide_sqrt_scale_arith_unit_tb_top.sv
`timescale 1ns/1ps
`include "dssau_map.svh"
// ============================================
// Bench: integer model of every operation, compared at each result.
module divide_sqrt_scale_arith_unit_tb_top;
  import dssau_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int errors = 0;
  int compares = 0;
  int m_hi = 0; // Model math register, upper word.
  int m_lo = 0; // Model math register, lower word.
  int e_dst = 0; // Expected destination.
  int e_ov = 0; // Expected overflow.
  int car = 0; // Expected carry.
  int da[6] = '{7, -7, 5, 0, 1, -32768};
  int db[6] = '{2, 2, 3, 5, 0, -1};
  int sq[7] = '{-1, 0, -32768, 32767, 2, 6, 7};
  int ss[7] = '{100, 3, -3, 32767, -32767, 30000, 0};
  int sr[7] = '{5000, 5000, 5000, 20000, 20000, 10000, 1234};
  int so[7] = '{0, 0, 0, -100, 0, 5000, 0};
  always #25 pclk = ~pclk;
  dssau_top i_dssau_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  dssau_prog_model i_dssau_prog_model (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ============================================
  // Verdict and end of run.
  task report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Compares a word result.
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Compares the interrupt line, settled at the falling edge.
  task chk_irq(input logic exp);
    @(negedge pclk);
    chk_val({31'h0, irq}, {31'h0, exp});
  endtask
  // Bus access; a lost answer ends the run.
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_dssau_prog_model.xfer(w, a, d);
    if (i_dssau_prog_model.tmo != 0)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  // Reads a register and compares it.
  task rdc(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk_val(i_dssau_prog_model.rdat, e);
  endtask
  // Loads operands, clears the minor flag, starts and waits for idle.
  task run(input dssau_op_t op, input int a, input int b, input int c);
    int i;
    wr(`DSSAU_OFF_OPA, 32'(a & 'hffff));
    wr(`DSSAU_OFF_OPB, 32'(b & 'hffff));
    wr(`DSSAU_OFF_OPC, 32'(c & 'hffff));
    wr(`DSSAU_OFF_FLAGS, 32'h10);
    wr(`DSSAU_OFF_CMD, {28'h0, 1'b1, op});
    for (i = 0; i < 64; i++)
    begin
      acc(1'b0, `DSSAU_OFF_FLAGS, 32'h0);
      if (i_dssau_prog_model.rdat[5] === 1'b0)
        break;
    end
    if (i == 64)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  // Checks destination, flags and math register against the model.
  task check_res;
    int d;
    d = e_dst & 'hffff;
    rdc(`DSSAU_OFF_DEST, 32'(d));
    rdc(`DSSAU_OFF_FLAGS, 32'(car | e_ov << 1 | (d == 0) << 2
      | (d >> 15) << 3 | e_ov << 4));
    rdc(`DSSAU_OFF_MATH_HI, 32'(m_hi & 'hffff));
    rdc(`DSSAU_OFF_MATH_LO, 32'(m_lo & 'hffff));
  endtask
  // ============================================
  // Model: division rounded half away from zero.
  function automatic longint rdiv(longint n, longint dv);
    longint q;
    longint r;
    q = n / dv;
    r = n % dv;
    if (2 * (r < 0 ? -r : r) >= (dv < 0 ? -dv : dv))
      q += ((n < 0) != (dv < 0)) ? -1 : 1;
    return q;
  endfunction
  // Divide and double divide; wrap keeps the low word of the result.
  task m_div(input longint n, input int dv, input bit wrap);
    longint q;
    e_ov = 1;
    e_dst = 32767;
    car = 0;
    if (dv != 0)
    begin
      q = rdiv(n, dv);
      m_hi = int'(n / dv);
      m_lo = int'(n % dv);
      if (q >= -32768 && q <= 32767)
      begin
        e_ov = 0;
        e_dst = int'(q);
      end
      else if (wrap)
        e_dst = int'(q);
    end
  endtask
  // Scale with checks before and after the offset.
  task m_scl(input int s, input int rt, input int off);
    longint q;
    q = rdiv(longint'(s) * rt, 10000);
    e_ov = 1;
    if (q > 32767)
      e_dst = 32767;
    else if (q < -32768)
      e_dst = -32768;
    else
    begin
      q += off;
      e_ov = int'(q > 32767 || q < -32768);
      e_dst = q > 32767 ? 32767 : (q < -32768 ? -32768 : int'(q));
    end
  endtask
  function automatic int s16();
    return int'($signed(16'($urandom)));
  endfunction
  // ============================================
  // Main sequence.
  initial
  begin
    int a, b, c, k, r;
    void'($urandom(32'hfdb7));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Every register, the zero flag included, comes out of reset clear.
    rdc(`DSSAU_OFF_DEST, 32'h0);
    rdc(`DSSAU_OFF_FLAGS, 32'h0);
    rdc(`DSSAU_OFF_MATH_HI, 32'h0);
    rdc(`DSSAU_OFF_MATH_LO, 32'h0);
    chk_irq(1'b0);
    $display("test reset done");
    for (k = 0; k < 20; k++)
    begin
      a = k < 6 ? da[k] : s16();
      b = k < 6 ? db[k] : s16() >>> (k % 12);
      run(OP_DIV, a, b, 0);
      m_div(a, b, 0);
      check_res();
    end
    wr(`DSSAU_OFF_CFG, 32'h1);
    run(OP_DIV, -32768, -1, 0);
    m_div(-32768, -1, 1);
    check_res();
    $display("test divide done");
    for (k = 0; k < 12; k++)
    begin
      m_hi = (k & 1) ? s16() : s16() & 'h3;
      m_lo = s16();
      a = k == 0 ? 0 : s16();
      wr(`DSSAU_OFF_MATH_HI, 32'(m_hi & 'hffff));
      wr(`DSSAU_OFF_MATH_LO, 32'(m_lo & 'hffff));
      run(OP_DDV, a, 0, 0);
      m_div(longint'($signed({m_hi[15:0], m_lo[15:0]})), a, 0);
      check_res();
    end
    wr(`DSSAU_OFF_CFG, 32'h0);
    run(OP_CLR, 0, 0, 0);
    e_dst = 0;
    e_ov = 0;
    car = 0;
    check_res();
    for (k = 0; k < 12; k++)
    begin
      a = k < 7 ? sq[k] : s16();
      run(OP_SQR, a, 0, 0);
      b = a < 0 ? -a : a;
      for (r = 0; (r + 1) * (r + 1) <= b; r++);
      e_dst = (b - r * r > r) ? r + 1 : r;
      e_ov = 0;
      car = int'(a < 0);
      check_res();
    end
    $display("test clear and root done");
    for (k = 0; k < 16; k++)
    begin
      a = k < 7 ? ss[k] : s16();
      b = k < 7 ? sr[k] : s16();
      c = k < 7 ? so[k] : s16();
      run(OP_SCL, a, b, c);
      m_scl(a, b, c);
      check_res();
    end
    wr(`DSSAU_OFF_CMD, {28'h0, 1'b0, OP_CLR});
    check_res();
    rdc(`DSSAU_OFF_CMD, {29'h0, OP_SCL});
    $display("test scale done");
    acc(1'b0, `DSSAU_OFF_IRQ_STAT, 32'h0);
    wr(`DSSAU_OFF_IRQ_MASK, 32'h0);
    run(OP_DIV, 1, 0, 0);
    chk_irq(1'b0);
    wr(`DSSAU_OFF_CFG, 32'h2);
    rdc(`DSSAU_OFF_MAJOR, 32'h20);
    rdc(`DSSAU_OFF_IRQ_STAT, 32'h7);
    rdc(`DSSAU_OFF_IRQ_STAT, 32'h0);
    wr(`DSSAU_OFF_MAJOR, 32'h0);
    wr(`DSSAU_OFF_FLAGS, 32'h10);
    wr(`DSSAU_OFF_CFG, 32'h2);
    rdc(`DSSAU_OFF_MAJOR, 32'h0);
    wr(`DSSAU_OFF_IRQ_MASK, 32'h1);
    run(OP_CLR, 0, 0, 0);
    chk_irq(1'b1);
    rdc(`DSSAU_OFF_IRQ_STAT, 32'h1);
    chk_irq(1'b0);
    acc(1'b0, 12'h030, 32'h0);
    // An unmapped read answers zero data with an error reply.
    chk_val(i_dssau_prog_model.rdat, 32'h0);
    chk_val({31'h0, i_dssau_prog_model.rerr}, 32'h1);
    $display("test status done");
    report_and_stop();
  end
endmodule

// file: bench/dssau_prog_model.sv
`timescale 1ns/1ps
// ============================================
// Program scan model: issues register accesses as an APB master.
module dssau_prog_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int tmo = 0; // Accesses that were never answered.
  logic [31:0] rdat; // Read data of the last access.
  logic rerr; // Error reply of the last access.
  // The bus starts idle.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer, held until pready is seen at a rising edge.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
      tmo++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// file: rtl/dssau_div_if.sv
`timescale 1ns/1ps
// Carries one unsigned divide request and its answer.
interface dssau_div_if #(parameter int W = 32) ();
  logic start;
  logic [W-1:0] dvd;
  logic [W-1:0] dvs;
  logic done;
  logic [W-1:0] quo;
  logic [W-1:0] rem;
  modport client (output start, output dvd, output dvs,
                  input done, input quo, input rem);
  modport server (input start, input dvd, input dvs,
                  output done, output quo, output rem);
endinterface

// file: rtl/dssau_divider.sv
`timescale 1ns/1ps
// Restoring divider, one quotient bit per clock, W cycles per divide.
module dssau_divider #(parameter int W = 32)
(
  input wire logic pclk,
  input wire logic presetn,
  dssau_div_if.server dif
);
  localparam int CW = $clog2(W) + 1;
  logic [W-1:0] rem_q, rem_d;
  logic [W-1:0] quo_q, quo_d;
  logic [W-1:0] dvs_q, dvs_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [W:0] r_sh;

  // ==========================================
  // Next state: shift and subtract while busy, else load on start.
  always_comb
  begin
    rem_d = rem_q;
    quo_d = quo_q;
    dvs_d = dvs_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    r_sh = {rem_q, quo_q[W-1]};
    if (busy_q)
    begin
      quo_d = {quo_q[W-2:0], 1'b0};
      // Subtract only when the partial remainder covers the divisor.
      if (r_sh >= {1'b0, dvs_q})
      begin
        rem_d = W'(r_sh - {1'b0, dvs_q});
        quo_d[0] = 1'b1;
      end
      else
      begin
        rem_d = r_sh[W-1:0];
      end
      cnt_d = CW'(cnt_q - CW'(1));
      if (cnt_q == CW'(1))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
    else if (dif.start)
    begin
      rem_d = '0;
      quo_d = dif.dvd;
      dvs_d = dif.dvs;
      cnt_d = CW'(W);
      busy_d = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rem_q <= '0;
      quo_q <= '0;
      dvs_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      dvs_q <= dvs_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  // Done pulses with the final quotient and remainder.
  assign dif.done = done_q;
  assign dif.quo = quo_q;
  assign dif.rem = rem_q;
endmodule

// file: rtl/dssau_map.svh
`ifndef DSSAU_MAP_SVH
`define DSSAU_MAP_SVH
// Register byte offsets on the APB window.
`define DSSAU_OFF_CMD 12'h000
`define DSSAU_OFF_OPA 12'h004
`define DSSAU_OFF_OPB 12'h008
`define DSSAU_OFF_OPC 12'h00c
`define DSSAU_OFF_DEST 12'h010
`define DSSAU_OFF_FLAGS 12'h014
`define DSSAU_OFF_MATH_HI 12'h018
`define DSSAU_OFF_MATH_LO 12'h01c
`define DSSAU_OFF_CFG 12'h020
`define DSSAU_OFF_MAJOR 12'h024
`define DSSAU_OFF_IRQ_STAT 12'h028
`define DSSAU_OFF_IRQ_MASK 12'h02c
// Field positions.
`define DSSAU_CMD_RUNG 3
`define DSSAU_FLG_MINOR 4
`define DSSAU_CFG_WRAP 0
`define DSSAU_CFG_SCAN 1
// Reset values.
`define DSSAU_RST_W16 16'h0000
`define DSSAU_RST_W32 32'h0000_0000
// Saturation values and result range.
`define DSSAU_POS_MAX 16'h7fff
`define DSSAU_NEG_MIN 16'h8000
`define DSSAU_RES_MAX 34'sh0_0000_7fff
`define DSSAU_RES_MIN 34'sh3_ffff_8000
// Major error code raised at scan end, and the rate divisor 10000.
`define DSSAU_MAJOR_CODE 16'h0020
`define DSSAU_SCALE_DIV 32'h0000_2710
`endif

// file: rtl/dssau_pkg.sv
package dssau_pkg;
  // Operation codes written into the command register.
  typedef enum logic [2:0]
  {
    OP_DIV = 3'b000,
    OP_DDV = 3'b001,
    OP_CLR = 3'b010,
    OP_SQR = 3'b011,
    OP_SCL = 3'b100
  } dssau_op_t;
  // Engine states.
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } dssau_state_t;
endpackage

// file: rtl/dssau_top.sv
`timescale 1ns/1ps
`include "dssau_map.svh"
module dssau_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import dssau_pkg::*;

  // ==========================================
  // State.
  dssau_state_t state_q, state_d; // Engine state.
  dssau_op_t op_q, op_d; // Operation in flight.
  logic [15:0] opa_q, opa_d; // Source A, or the only source.
  logic [15:0] opb_q, opb_d; // Source B, or the rate.
  logic [15:0] opc_q, opc_d; // Scale offset.
  logic [15:0] dest_q, dest_d; // Destination word.
  logic [31:0] math_q, math_d; // Math register.
  logic c_q, c_d, v_q, v_d, z_q, z_d, s_q, s_d; // Status flags.
  logic minor_q, minor_d; // Minor error flag.
  logic wrap_q, wrap_d; // Overflow wrap select.
  logic [15:0] major_q, major_d; // Major error code.
  logic [2:0] ist_q, ist_d; // Sticky events: done, overflow, major.
  logic [2:0] imask_q, imask_d; // Interrupt mask.
  logic neg_q, neg_d; // Quotient is negative.
  logic rneg_q, rneg_d; // Dividend is negative.
  logic [31:0] dvs_q, dvs_d; // Divisor magnitude.
  logic [31:0] prdata_q, prdata_d; // Read data captured at setup.

  // ==========================================
  // Decode and datapath nets.
  logic wr_en, rd_en, hit, cmd_go, cmd_off, fin, minor_set, fin_evt;
  logic [31:0] rmux;
  dssau_op_t cmd_op;
  logic [31:0] src_dvd, src_dvs, prod;
  logic src_neg, src_rneg, rup, rng_ovf;
  logic [32:0] qr;
  logic [33:0] sres;
  logic [31:0] strunc, srem;
  logic [16:0] sum17;
  logic [15:0] res_w;
  logic wr_res;

  dssau_div_if #(.W(32)) dif ();

  // Shared divider for divide, double divide and scale.
  dssau_divider #(.W(32)) u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .dif(dif)
  );

  // Magnitude of a signed 32-bit value.
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? 32'h0000_0000 - v : v;
  endfunction

  // Rounded square root of a 17-bit magnitude.
  function automatic logic [15:0] isqrt(input logic [16:0] x);
    logic [15:0] r;
    logic [15:0] t;
    logic [31:0] rem;
    r = 16'h0000;
    for (int i = 7; i >= 0; i--)
    begin
      t = r | (16'h0001 << i);
      if ((32'(t) * 32'(t)) <= 32'(x))
        r = t;
    end
    rem = 32'(x) - 32'(r) * 32'(r);
    // Round up when x passes (r + 0.5) squared.
    if (rem > 32'(r))
      r = 16'(r + 16'h0001);
    isqrt = r;
  endfunction

  // ==========================================
  // APB decode: writes take effect in the access phase.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cmd_op = dssau_op_t'(pwdata[2:0]);
  assign cmd_go = wr_en && (paddr == `DSSAU_OFF_CMD) &&
    pwdata[`DSSAU_CMD_RUNG] && (state_q == ST_IDLE);
  assign cmd_off = wr_en && (paddr == `DSSAU_OFF_CMD) &&
    !pwdata[`DSSAU_CMD_RUNG] && (state_q == ST_IDLE);
  assign fin = (state_q == ST_WAIT) && dif.done;

  // Read mux with unmapped detection.
  always_comb
  begin
    hit = 1'b1;
    rmux = 32'h0000_0000;
    if (paddr == `DSSAU_OFF_CMD)
      rmux = {28'h0000000, 1'b0, op_q};
    else if (paddr == `DSSAU_OFF_OPA)
      rmux = {16'h0000, opa_q};
    else if (paddr == `DSSAU_OFF_OPB)
      rmux = {16'h0000, opb_q};
    else if (paddr == `DSSAU_OFF_OPC)
      rmux = {16'h0000, opc_q};
    else if (paddr == `DSSAU_OFF_DEST)
      rmux = {16'h0000, dest_q};
    else if (paddr == `DSSAU_OFF_FLAGS)
      rmux = {26'h0000000, state_q == ST_WAIT, minor_q, s_q, z_q, v_q, c_q};
    else if (paddr == `DSSAU_OFF_MATH_HI)
      rmux = {16'h0000, math_q[31:16]};
    else if (paddr == `DSSAU_OFF_MATH_LO)
      rmux = {16'h0000, math_q[15:0]};
    else if (paddr == `DSSAU_OFF_CFG)
      rmux = {31'h00000000, wrap_q};
    else if (paddr == `DSSAU_OFF_MAJOR)
      rmux = {16'h0000, major_q};
    else if (paddr == `DSSAU_OFF_IRQ_STAT)
      rmux = {29'h00000000, ist_q};
    else if (paddr == `DSSAU_OFF_IRQ_MASK)
      rmux = {29'h00000000, imask_q};
    else
      hit = 1'b0;
  end

  // Zero wait states; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign irq = |(ist_q & imask_q);

  // ==========================================
  // Operand selection for the divider at command time.
  assign prod = 32'($signed(opa_q) * $signed(opb_q));
  always_comb
  begin
    src_dvd = mag32({{16{opa_q[15]}}, opa_q});
    src_dvs = mag32({{16{opb_q[15]}}, opb_q});
    src_neg = opa_q[15] ^ opb_q[15];
    src_rneg = opa_q[15];
    if (cmd_op == OP_DDV)
    begin
      // Math register is the dividend, source A the divisor.
      src_dvd = mag32(math_q);
      src_dvs = mag32({{16{opa_q[15]}}, opa_q});
      src_neg = math_q[31] ^ opa_q[15];
      src_rneg = math_q[31];
    end
    else if (cmd_op == OP_SCL)
    begin
      // Product over 10000 gives the scaled source.
      src_dvd = mag32(prod);
      src_dvs = `DSSAU_SCALE_DIV;
      src_neg = prod[31];
      src_rneg = prod[31];
    end
  end

  // ==========================================
  // Result shaping once the divider answers.
  always_comb
  begin
    rup = {dif.rem, 1'b0} >= {1'b0, dvs_q};
    qr = {1'b0, dif.quo} + {32'h0000_0000, rup};
    sres = neg_q ? 34'h0 - {1'b0, qr} : {1'b0, qr};
    rng_ovf = ($signed(sres) > `DSSAU_RES_MAX) ||
      ($signed(sres) < `DSSAU_RES_MIN);
    strunc = neg_q ? 32'h0000_0000 - dif.quo : dif.quo;
    srem = rneg_q ? 32'h0000_0000 - dif.rem : dif.rem;
    sum17 = {sres[15], sres[15:0]} + {opc_q[15], opc_q};
  end

  // ==========================================
  // Engine next state: start, single-cycle ops, finish.
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    neg_d = neg_q;
    rneg_d = rneg_q;
    dvs_d = dvs_q;
    dest_d = dest_q;
    math_d = math_q;
    c_d = c_q;
    v_d = v_q;
    z_d = z_q;
    s_d = s_q;
    minor_set = 1'b0;
    fin_evt = 1'b0;
    res_w = `DSSAU_RST_W16;
    wr_res = 1'b0;
    dif.start = 1'b0;
    dif.dvd = src_dvd;
    dif.dvs = src_dvs;
    if (cmd_go)
    begin
      op_d = cmd_op;
      case (cmd_op)
        OP_CLR:
        begin
          // Destination zero, so zero sets and sign clears.
          c_d = 1'b0;
          v_d = 1'b0;
          wr_res = 1'b1;
          fin_evt = 1'b1;
        end
        OP_SQR:
        begin
          res_w = isqrt(opa_q[15] ? 17'h0 - {1'b1, opa_q} : {1'b0, opa_q});
          c_d = opa_q[15];
          v_d = 1'b0;
          wr_res = 1'b1;
          fin_evt = 1'b1;
        end
        OP_DIV, OP_DDV:
        begin
          if (src_dvs == 32'h0000_0000)
          begin
            // Zero divisor: overflow at once, math register kept.
            c_d = 1'b0;
            v_d = 1'b1;
            minor_set = 1'b1;
            res_w = `DSSAU_POS_MAX;
            wr_res = 1'b1;
            fin_evt = 1'b1;
          end
          else
          begin
            dif.start = 1'b1;
            state_d = ST_WAIT;
          end
        end
        OP_SCL:
        begin
          dif.start = 1'b1;
          state_d = ST_WAIT;
        end
        default:
        begin
          // Unknown codes do nothing.
          op_d = op_q;
        end
      endcase
      neg_d = src_neg;
      rneg_d = src_rneg;
      dvs_d = src_dvs;
    end
    else if (fin)
    begin
      state_d = ST_IDLE;
      fin_evt = 1'b1;
      wr_res = 1'b1;
      if (op_q == OP_SCL)
      begin
        if (rng_ovf)
        begin
          // Product overflow saturates whatever the offset.
          v_d = 1'b1;
          minor_set = 1'b1;
          res_w = sres[33] ? `DSSAU_NEG_MIN : `DSSAU_POS_MAX;
        end
        else if (sum17[16] != sum17[15])
        begin
          // Overflow after the offset is added.
          v_d = 1'b1;
          minor_set = 1'b1;
          res_w = sum17[16] ? `DSSAU_NEG_MIN : `DSSAU_POS_MAX;
        end
        else
        begin
          v_d = 1'b0;
          res_w = sum17[15:0];
        end
      end
      else
      begin
        // Both divides load unrounded quotient and remainder.
        c_d = 1'b0;
        math_d = {strunc[15:0], srem[15:0]};
        v_d = rng_ovf;
        minor_set = rng_ovf;
        if (!rng_ovf)
          res_w = sres[15:0];
        else if (wrap_q && (op_q == OP_DIV))
          res_w = sres[15:0];
        else
          res_w = `DSSAU_POS_MAX;
      end
    end
    else if (wr_en && (state_q == ST_IDLE))
    begin
      // Software loads a product into the math register.
      if (paddr == `DSSAU_OFF_MATH_HI)
        math_d[31:16] = pwdata[15:0];
      else if (paddr == `DSSAU_OFF_MATH_LO)
        math_d[15:0] = pwdata[15:0];
    end
    if (wr_res)
    begin
      dest_d = res_w;
      z_d = (res_w == `DSSAU_RST_W16);
      s_d = res_w[15];
    end
  end

  // ==========================================
  // Register file next state.
  always_comb
  begin
    opa_d = opa_q;
    opb_d = opb_q;
    opc_d = opc_q;
    wrap_d = wrap_q;
    imask_d = imask_q;
    major_d = major_q;
    minor_d = minor_q;
    prdata_d = prdata_q;
    ist_d = ist_q;
    // Capture read data in the setup phase.
    if (psel && !penable && !pwrite)
      prdata_d = rmux;
    if (wr_en)
    begin
      if ((paddr == `DSSAU_OFF_OPA) && (state_q == ST_IDLE))
        opa_d = pwdata[15:0];
      else if ((paddr == `DSSAU_OFF_OPB) && (state_q == ST_IDLE))
        opb_d = pwdata[15:0];
      else if ((paddr == `DSSAU_OFF_OPC) && (state_q == ST_IDLE))
        opc_d = pwdata[15:0];
      else if (paddr == `DSSAU_OFF_FLAGS)
        minor_d = minor_q && !pwdata[`DSSAU_FLG_MINOR];
      else if (paddr == `DSSAU_OFF_CFG)
      begin
        wrap_d = pwdata[`DSSAU_CFG_WRAP];
        // Scan end with the minor flag still up declares a major.
        if (pwdata[`DSSAU_CFG_SCAN] && minor_q)
          major_d = `DSSAU_MAJOR_CODE;
      end
      else if (paddr == `DSSAU_OFF_MAJOR)
        major_d = `DSSAU_RST_W16;
      else if (paddr == `DSSAU_OFF_IRQ_MASK)
        imask_d = pwdata[2:0];
    end
    // Reading clears only the bits that were captured.
    if (rd_en && (paddr == `DSSAU_OFF_IRQ_STAT))
      ist_d = ist_q & ~prdata_q[2:0];
    // Hardware sets win over software clears.
    if (minor_set)
      minor_d = 1'b1;
    ist_d = ist_d | {major_d != major_q && major_d != 16'h0000,
      minor_set, fin_evt};
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_DIV;
      opa_q <= `DSSAU_RST_W16;
      opb_q <= `DSSAU_RST_W16;
      opc_q <= `DSSAU_RST_W16;
      dest_q <= `DSSAU_RST_W16;
      math_q <= `DSSAU_RST_W32;
      {c_q, v_q, z_q, s_q, minor_q, wrap_q} <= 6'h00;
      major_q <= `DSSAU_RST_W16;
      ist_q <= 3'h0;
      imask_q <= 3'h0;
      {neg_q, rneg_q} <= 2'h0;
      dvs_q <= `DSSAU_RST_W32;
      prdata_q <= `DSSAU_RST_W32;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      opa_q <= opa_d;
      opb_q <= opb_d;
      opc_q <= opc_d;
      dest_q <= dest_d;
      math_q <= math_d;
      {c_q, v_q, z_q, s_q, minor_q, wrap_q} <=
        {c_d, v_d, z_d, s_d, minor_d, wrap_d};
      major_q <= major_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      {neg_q, rneg_q} <= {neg_d, rneg_d};
      dvs_q <= dvs_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go_div;
    cmd_go && (cmd_op == OP_DIV) && (src_dvs != 32'h0000_0000);
  endsequence
  sequence s_go_zero;
    cmd_go && ((cmd_op == OP_DIV) || (cmd_op == OP_DDV)) &&
      (src_dvs == 32'h0000_0000);
  endsequence

  a_div_latency: assert property (s_go_div |-> ##33 fin)
    else $error("Divide did not finish in 33 cycles.");
  a_div_zero: assert property (s_go_zero |=>
    v_q && minor_q && (dest_q == `DSSAU_POS_MAX))
    else $error("Zero divisor did not overflow.");
  a_clear_flags: assert property (
    cmd_go && (cmd_op == OP_CLR) |=>
      (dest_q == 16'h0000) && z_q && !c_q && !v_q && !s_q)
    else $error("Clear left wrong flags.");
  a_sqr_flags: assert property (
    cmd_go && (cmd_op == OP_SQR) |=>
      !v_q && !s_q && (c_q == $past(opa_q[15])))
    else $error("Square root flags wrong.");
  a_rung_hold: assert property (cmd_off |=>
    $stable(dest_q) && $stable(math_q) && $stable(v_q))
    else $error("False rung changed state.");
  a_ovf_minor: assert property ($rose(v_q) |-> minor_q)
    else $error("Overflow without minor flag.");
  a_div_carry: assert property (
    fin && (op_q != OP_SCL) |=> !c_q)
    else $error("Divide left carry set.");
  a_scale_carry: assert property (
    fin && (op_q == OP_SCL) |=> (c_q == $past(c_q)))
    else $error("Scale touched carry.");
  a_scale_sat: assert property (
    fin && (op_q == OP_SCL) && rng_ovf && !sres[33] |=>
      v_q && (dest_q == `DSSAU_POS_MAX))
    else $error("Scale product overflow not saturated.");
  a_ddv_wrap: assert property (
    fin && (op_q == OP_DDV) && rng_ovf |=> dest_q == `DSSAU_POS_MAX)
    else $error("Double divide overflow not 32767.");
  a_major_code: assert property (
    wr_en && (paddr == `DSSAU_OFF_CFG) && pwdata[`DSSAU_CFG_SCAN] &&
      minor_q |=> major_q == `DSSAU_MAJOR_CODE)
    else $error("Major code not raised at scan end.");
endmodule
